// ==== sdf_framing_port.sv ====
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module sdf_framing_port #(
    parameter int PorCycles = sdf_pkg::POR_CYCLES_DEFAULT
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             arst_n,
    // device pins: enable and test straps
    input  wire logic             deviceEnable,
    input  wire logic             pattern_test_enable,
    input  wire logic             factory_test_enable,
    // transmit side from the protocol device
    input  wire logic             tx_reference_clock,
    input  wire logic [15:0]      txWord,
    input  wire logic             txWordValid,
    input  wire logic             tx_fault_code,
    output logic                  txSymValid,
    output sdf_pkg::sdf_sym_t     txSym,
    // receive side from the aligner and signal detector
    input  wire logic             rxBitTick,
    input  wire sdf_pkg::sdf_sym_t rxSym,
    input  wire logic             signal_loss,
    // receive pins toward the protocol device
    output logic                  rxWordClock,
    output logic [15:0]           rxDataOut,
    output logic                  rxDataOe,
    output logic                  rxFaultOut,
    output logic                  rxFaultOe,
    output logic                  rxValidOut,
    output logic                  rxValidOe,
    // apb slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic                  pready,
    output logic [31:0]           prdata,
    output logic                  pslverr
);

    // refuse a reset length the counter cannot hold
    if (PorCycles < 1 || PorCycles > 65535)
    begin : g_bad_por
        $error("PorCycles out of range");
    end

    localparam logic [15:0] PorLast = 16'(PorCycles - 1);

    // whole block state
    typedef struct packed {
        sdf_pkg::sdf_mode_t mode;
        logic [15:0]        porCnt;     // power-on reset timer
        logic [4:0]         bitCnt;     // recovered bits within word
        logic               wordClk;    // recovered word clock
        logic               txClkPrev;  // last sampled reference clock
        logic               idleAlt;    // picks second idle character
        logic [6:0]         txPrbs;     // transmit pattern generator
        logic [6:0]         rxPrbs;     // receive pattern predictor
        sdf_pkg::sdf_sym_t  txSym;
        logic               txSymValid;
        logic [15:0]        rxData;
        logic               rxValid;
        logic               rxFault;
        logic               pass;       // pattern check result
        logic               dataOe;
        logic               faultOe;
        logic               validOe;
        logic               faultPin;
        logic               validPin;
        logic [1:0]         ctrl;       // software control bits
        logic [15:0]        errCnt;     // errored words received
        logic               pready;
        logic [31:0]        prdata;
        logic               pslverr;
    } sdf_state_t;

    sdf_state_t st_q;
    sdf_state_t st_d;

    // sixteen steps of the x^7+x^6+1 pattern; returns {next state, word}
    function automatic logic [22:0] prbsWord(input logic [6:0] seed);
        logic [6:0]  s;
        logic [15:0] w;
        logic        nb;
        s = seed;
        w = 16'h0000;
        for (int i = 0; i < 16; i++)
        begin
            nb   = s[6] ^ s[5];
            w[i] = nb;
            s    = {s[5:0], nb};
        end
        return {s, w};
    endfunction

    // next-state logic
    always_comb
    begin
        logic              enabled;
        logic              txEdge;
        logic              patternOn;
        logic              wordDone;
        logic [22:0]       txPat;
        logic [22:0]       rxPat;
        logic [4:0]        nextCnt;
        logic              access;
        sdf_pkg::sdf_sym_t rs;
        enabled   = 1'b0;
        txEdge    = 1'b0;
        patternOn = 1'b0;
        wordDone  = 1'b0;
        txPat     = 23'h00_0000;
        rxPat     = 23'h00_0000;
        nextCnt   = 5'h00;
        access    = 1'b0;
        rs        = rxSym;
        st_d      = st_q;

        enabled   = deviceEnable & ~st_q.ctrl[sdf_pkg::CTRL_SOFT_PD];
        patternOn = pattern_test_enable | st_q.ctrl[sdf_pkg::CTRL_FORCE_PT];
        // factory test input is never acted on
        txEdge    = tx_reference_clock & ~st_q.txClkPrev;
        st_d.txClkPrev = tx_reference_clock;

        // mode sequencing
        unique case (st_q.mode)
            sdf_pkg::MODE_PWRDN:
            begin
                // only the signal detector drives a pin
                if (enabled)
                begin
                    st_d.mode   = sdf_pkg::MODE_POR; // RL19
                    st_d.porCnt = 16'h0000;
                end
            end
            sdf_pkg::MODE_POR:
            begin
                if (!enabled)
                    st_d.mode = sdf_pkg::MODE_PWRDN; // RL19
                else if (st_q.porCnt == PorLast)
                    st_d.mode = sdf_pkg::MODE_RUN;
                else
                    st_d.porCnt = st_q.porCnt + 16'h0001;
            end
            sdf_pkg::MODE_RUN:
            begin
                if (!enabled)
                    st_d.mode = sdf_pkg::MODE_PWRDN; // RL19
            end
            default:
            begin
                // illegal code recovers through power-down
                st_d.mode = sdf_pkg::MODE_PWRDN;
            end
        endcase

        // transmit encoder, one word per reference rising edge
        st_d.txSymValid = 1'b0;
        if (st_q.mode == sdf_pkg::MODE_RUN && txEdge) // RL11
        begin
            st_d.txSymValid = 1'b1;
            if (patternOn)
            begin
                // pattern replaces the partner's data
                txPat       = prbsWord(st_q.txPrbs);
                st_d.txPrbs = txPat[22:16];
                st_d.txSym  = {1'b0, txPat[15:8], 1'b0, txPat[7:0]};
            end
            else if (txWordValid && tx_fault_code)
                // error propagation
                st_d.txSym = {1'b1, sdf_pkg::CODE_K30_7,
                              1'b1, sdf_pkg::CODE_K30_7}; // RL14 RL17
            else if (tx_fault_code)
                // carrier extension
                st_d.txSym = {1'b1, sdf_pkg::CODE_K23_7,
                              1'b1, sdf_pkg::CODE_K23_7}; // RL15 RL17
            else if (txWordValid)
                // payload
                st_d.txSym = {1'b0, txWord[15:8], 1'b0, txWord[7:0]}; // RL16
            else
            begin
                // idle: comma first, then alternating data character
                st_d.txSym   = {st_q.idleAlt ? {1'b0, sdf_pkg::CODE_D16_2}
                                             : {1'b0, sdf_pkg::CODE_D5_6},
                                1'b1, sdf_pkg::CODE_K28_5}; // RL18
                st_d.idleAlt = ~st_q.idleAlt;
            end
        end

        // recovered word clock: low for ten bits, high for ten
        if (st_q.mode == sdf_pkg::MODE_RUN)
        begin
            if (rxBitTick)
            begin
                wordDone = (st_q.bitCnt == sdf_pkg::BITS_PER_WORD - 5'h01);
                nextCnt  = wordDone ? 5'h00 : st_q.bitCnt + 5'h01;
                st_d.bitCnt  = nextCnt;
                st_d.wordClk = (nextCnt >= sdf_pkg::BITS_HALF); // RL1
            end
        end
        else
        begin
            st_d.bitCnt  = 5'h00;
            st_d.wordClk = 1'b0; // RL2
        end

        // decode one word at the falling word clock edge
        if (wordDone)
        begin
            rxPat       = prbsWord(st_q.rxPrbs);
            st_d.pass   = ({rs.byteHi, rs.byteLo} == rxPat[15:0]) & ~rs.kHi & ~rs.kLo;
            st_d.rxPrbs = {<<{rs.byteHi[7:1]}};
            if (signal_loss)
            begin
                // loss of signal report
                st_d.rxValid = 1'b1; // RL8
                st_d.rxFault = 1'b1; // RL8
                st_d.rxData  = 16'hFFFF; // RL8
            end
            else if (!rs.kHi && !rs.kLo)
            begin
                // payload: valid stays high for every word of a frame
                st_d.rxValid = 1'b1; // RL7 RL20
                st_d.rxFault = 1'b0;
                st_d.rxData  = {rs.byteHi, rs.byteLo};
            end
            else if (rs.kHi && rs.kLo && rs.byteHi == sdf_pkg::CODE_K23_7
                     && rs.byteLo == sdf_pkg::CODE_K23_7)
            begin
                // carrier extension
                st_d.rxValid = 1'b0; // RL4 RL20
                st_d.rxFault = 1'b1; // RL4
                st_d.rxData  = {rs.byteHi, rs.byteLo};
            end
            else if (rs.kLo && rs.byteLo == sdf_pkg::CODE_K28_5)
            begin
                // idle ends the frame: valid drops before next rising edge
                st_d.rxValid = 1'b0; // RL7 RL20
                st_d.rxFault = 1'b0;
                st_d.rxData  = {rs.byteHi, rs.byteLo};
            end
            else
            begin
                // error propagation or any unknown control pair
                st_d.rxValid = 1'b1; // RL3 RL20
                st_d.rxFault = 1'b1; // RL3
                st_d.rxData  = {rs.byteHi, rs.byteLo};
                st_d.errCnt  = st_q.errCnt + 16'h0001;
            end
        end

        // pin drive per mode
        unique case (st_q.mode)
            sdf_pkg::MODE_RUN:
            begin
                st_d.dataOe   = 1'b1;
                st_d.faultOe  = 1'b1;
                st_d.validOe  = 1'b1;
                st_d.faultPin = patternOn ? st_d.pass : st_d.rxFault; // RL6
                st_d.validPin = st_d.rxValid;
            end
            sdf_pkg::MODE_PWRDN:
            begin
                st_d.dataOe   = 1'b0;
                st_d.faultOe  = 1'b0;
                st_d.validOe  = 1'b1;
                st_d.faultPin = 1'b0;
                st_d.validPin = ~signal_loss; // RL9
            end
            default:
            begin
                // power-on reset: fault and valid float
                st_d.dataOe   = 1'b0;
                st_d.faultOe  = 1'b0; // RL5
                st_d.validOe  = 1'b0; // RL5
                st_d.faultPin = 1'b0;
                st_d.validPin = 1'b0;
            end
        endcase

        // apb: one wait state, reads decoded at the edge that raises pready, writes done at the completing edge
        access = psel & penable;
        st_d.pready = access & ~st_q.pready;
        if (access && !st_q.pready)
        begin
            st_d.pslverr = 1'b0;
            unique case (paddr)
                sdf_pkg::REG_CTRL:
                    st_d.prdata = {30'h0000_0000, st_q.ctrl};
                sdf_pkg::REG_STATUS:
                    st_d.prdata = {25'h000_0000, st_q.rxFault, st_q.rxValid,
                                   st_q.pass, signal_loss, st_q.mode};
                sdf_pkg::REG_ERRCNT:
                    st_d.prdata = {16'h0000, st_q.errCnt};
                default:
                begin
                    st_d.prdata  = 32'h0000_0000;
                    st_d.pslverr = 1'b1;
                end
            endcase
        end
        else if (!access)
        begin
            st_d.prdata  = 32'h0000_0000;
            st_d.pslverr = 1'b0;
        end
        if (access && st_q.pready && pwrite && paddr == sdf_pkg::REG_CTRL)
            st_d.ctrl = pwdata[1:0];
    end

    // state register
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_q        <= '0;
            st_q.mode   <= sdf_pkg::MODE_POR;
            st_q.txPrbs <= 7'h7F;
            st_q.rxPrbs <= 7'h7F;
            st_q.ctrl   <= sdf_pkg::CTRL_RESET;
        end
        else
            st_q <= st_d;
    end

    // outputs straight from the state register
    assign txSym       = st_q.txSym;
    assign txSymValid  = st_q.txSymValid;
    assign rxWordClock = st_q.wordClk;
    assign rxDataOut   = st_q.rxData;
    assign rxDataOe    = st_q.dataOe;
    assign rxFaultOut  = st_q.faultPin;
    assign rxFaultOe   = st_q.faultOe;
    assign rxValidOut  = st_q.validPin;
    assign rxValidOe   = st_q.validOe;
    assign pready      = st_q.pready;
    assign prdata      = st_q.prdata;
    assign pslverr     = st_q.pslverr;

endmodule

// ==== sdf_pkg.sv ====
// Behaviour
// RL1 - word clock is bit clock divided by twenty
// RL2 - word clock held low during power-on reset
// RL3 - fault with valid marks errored frame
// RL4 - fault without valid marks carrier extension
// RL5 - fault and valid pins float during reset
// RL6 - fault pin shows pattern pass when testing
// RL7 - valid spans whole frame, drops after it
// RL8 - signal loss drives valid, fault, data high
// RL9 - power-down valid pin shows signal detector
// RL10 - factory test input stays low outside
// RL11 - transmit word captured on reference rising edge
// RL12 - partner raises valid with first preamble word
// RL13 - partner drops valid after final word
// RL14 - valid with fault sends error propagation
// RL15 - fault without valid sends carrier extension
// RL16 - valid without fault sends payload word
// RL17 - two K23.7 or two K30.7 per word
// RL18 - idle is K28.5 then D5.6 or D16.2
// RL19 - disable powers down, re-enable runs reset
// RL20 - decoder maps code pairs back onto flags
package sdf_pkg;

    // one 18-bit code group before line coding: two control-flagged bytes
    typedef struct packed {
        logic       kHi;   // upper byte is a control code
        logic [7:0] byteHi;
        logic       kLo;   // lower byte is a control code
        logic [7:0] byteLo;
    } sdf_sym_t;

    // operating modes, one-hot
    typedef enum logic [2:0] {
        MODE_PWRDN = 3'b001,
        MODE_POR   = 3'b010,
        MODE_RUN   = 3'b100
    } sdf_mode_t;

    // control and data code values
    localparam logic [7:0] CODE_K28_5 = 8'hBC;
    localparam logic [7:0] CODE_D5_6  = 8'hC5;
    localparam logic [7:0] CODE_D16_2 = 8'h50;
    localparam logic [7:0] CODE_K23_7 = 8'hF7;
    localparam logic [7:0] CODE_K30_7 = 8'hFE;

    // recovered bit ticks per word and half word
    localparam logic [4:0] BITS_PER_WORD = 5'h14;
    localparam logic [4:0] BITS_HALF     = 5'h0A;

    // register offsets (byte addresses)
    localparam logic [11:0] REG_CTRL   = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_ERRCNT = 12'h008;

    // control register fields and reset values
    localparam int          CTRL_SOFT_PD  = 0;
    localparam int          CTRL_FORCE_PT = 1;
    localparam logic [1:0]  CTRL_RESET    = 2'h0;

    // status register fields
    localparam int STAT_MODE_LO = 0;  // three one-hot mode bits
    localparam int STAT_LOSS    = 3;
    localparam int STAT_PASS    = 4;
    localparam int STAT_RXVALID = 5;
    localparam int STAT_RXFAULT = 6;

    // default power-on reset length in clock cycles
    localparam int POR_CYCLES_DEFAULT = 64;

endpackage

// ==== sdf_framing_port_asserts.sv ====
`timescale 1ns/1ps
module sdf_framing_port_asserts #(
    parameter int PorCycles = sdf_pkg::POR_CYCLES_DEFAULT
) (
    // clock and reset
    input wire logic              sys_clk,
    input wire logic              arst_n,
    // straps
    input wire logic              deviceEnable,
    input wire logic              pattern_test_enable,
    // transmit side
    input wire logic [15:0]       txWord,
    input wire logic              txWordValid,
    input wire logic              tx_fault_code,
    input wire logic              txSymValid,
    input wire sdf_pkg::sdf_sym_t txSym,
    // receive side
    input wire logic              rxBitTick,
    input wire sdf_pkg::sdf_sym_t rxSym,
    input wire logic              signal_loss,
    input wire logic              rxWordClock,
    input wire logic [15:0]       rxDataOut,
    input wire logic              rxFaultOut,
    input wire logic              rxFaultOe,
    input wire logic              rxValidOut,
    input wire logic              rxValidOe,
    // bus handshake
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pready
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    // the two control pairs of the transmit encoding
    localparam sdf_pkg::sdf_sym_t ErrPair = {1'h1, sdf_pkg::CODE_K30_7, 1'h1, sdf_pkg::CODE_K30_7};
    localparam sdf_pkg::sdf_sym_t ExtPair = {1'h1, sdf_pkg::CODE_K23_7, 1'h1, sdf_pkg::CODE_K23_7};

    // ticks seen since the word clock last moved, armed once running
    logic [4:0] tickCnt_q;
    logic       lastClk_q;
    logic       armed_q;

    // expected code group for one transmit word
    function automatic logic txOk(logic v, logic f, logic [15:0] w, sdf_pkg::sdf_sym_t s);
        if (v && f) return s == ErrPair;
        if (v) return s == {1'h0, w[15:8], 1'h0, w[7:0]};
        if (f) return s == ExtPair;
        return s.kLo && s.byteLo == sdf_pkg::CODE_K28_5 && !s.kHi
            && (s.byteHi == sdf_pkg::CODE_D5_6 || s.byteHi == sdf_pkg::CODE_D16_2);
    endfunction

    // expected {valid, fault} for one received code pair
    function automatic logic [1:0] rxExp(sdf_pkg::sdf_sym_t s);
        if (!s.kHi && !s.kLo) return 2'h2;
        if (s == ExtPair) return 2'h1;
        if (s.kLo && s.byteLo == sdf_pkg::CODE_K28_5) return 2'h0;
        return 2'h3;
    endfunction

    // half-period tick counter for the word clock
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tickCnt_q <= 5'h00;
            lastClk_q <= 1'h0;
            armed_q   <= 1'h0;
        end
        else
        begin
            lastClk_q <= rxWordClock;
            if (rxWordClock != lastClk_q)
            begin
                tickCnt_q <= {4'h0, rxBitTick};
                armed_q   <= rxFaultOe;
            end
            else if (rxBitTick)
                tickCnt_q <= tickCnt_q + 5'h01;
            if (!rxFaultOe)
                armed_q <= 1'h0;
        end
    end

    property p_clkDiv;
        rxWordClock != lastClk_q && armed_q && rxFaultOe |-> tickCnt_q == sdf_pkg::BITS_HALF;
    endproperty
    a_clkDiv: assert property (p_clkDiv) else $error("word clock half period wrong");
    property p_porFloat;
        $rose(deviceEnable) |-> ##3 (!rxFaultOe && !rxValidOe && !rxWordClock);
    endproperty
    a_porFloat: assert property (p_porFloat) else $error("pins active in reset");
    property p_pdDetect;
        (!deviceEnable && $stable(signal_loss)) [*4] |-> rxValidOe && rxValidOut == !signal_loss;
    endproperty
    a_pdDetect: assert property (p_pdDetect) else $error("detector pin wrong");
    property p_lossHigh;
        $fell(rxWordClock) && rxFaultOe && $past(signal_loss) |->
            rxValidOut && rxDataOut == 16'hFFFF && (pattern_test_enable || rxFaultOut);
    endproperty
    a_lossHigh: assert property (p_lossHigh) else $error("loss not reported");
    property p_rxDecode;
        $fell(rxWordClock) && rxFaultOe && !pattern_test_enable && !$past(signal_loss) |->
            {rxValidOut, rxFaultOut} == rxExp($past(rxSym));
    endproperty
    a_rxDecode: assert property (p_rxDecode) else $error("receive flags wrong");
    property p_txCode;
        txSymValid && !$past(pattern_test_enable) |->
            txOk($past(txWordValid, 2), $past(tx_fault_code, 2), $past(txWord, 2), txSym);
    endproperty
    a_txCode: assert property (p_txCode) else $error("transmit code wrong");
    property p_txOnce;
        txSymValid |=> !txSymValid;
    endproperty
    a_txOnce: assert property (p_txOnce) else $error("word strobe too long");
    property p_apbWait;
        psel && penable && !$past(penable) |-> !pready ##1 pready;
    endproperty
    a_apbWait: assert property (p_apbWait) else $error("bus wait state wrong");
endmodule

bind sdf_framing_port sdf_framing_port_asserts #(.PorCycles(PorCycles)) chk_u (
    .sys_clk(sys_clk), .arst_n(arst_n), .deviceEnable(deviceEnable),
    .pattern_test_enable(pattern_test_enable), .txWord(txWord), .txWordValid(txWordValid),
    .tx_fault_code(tx_fault_code), .txSymValid(txSymValid), .txSym(txSym),
    .rxBitTick(rxBitTick), .rxSym(rxSym), .signal_loss(signal_loss),
    .rxWordClock(rxWordClock), .rxDataOut(rxDataOut), .rxFaultOut(rxFaultOut),
    .rxFaultOe(rxFaultOe), .rxValidOut(rxValidOut), .rxValidOe(rxValidOe),
    .psel(psel), .penable(penable), .pready(pready));

// ==== sdf_proto_model.sv ====
`timescale 1ns/1ps
module sdf_proto_model (
    // clock and reset
    input wire logic   sys_clk,
    input wire logic   arst_n,
    // transmit pins toward the port
    output logic        tx_reference_clock,
    output logic [15:0] txWord,
    output logic        txWordValid,
    output logic        tx_fault_code
);
    // phase in the 8-cycle reference period and index of the word
    logic [5:0] cnt_q;

    // free-running reference clock, words change far from its rise
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_q              <= 6'h00;
            tx_reference_clock <= 1'h0;
            txWord             <= 16'h0000;
            txWordValid        <= 1'h0;
            tx_fault_code      <= 1'h0;
        end
        else
        begin
            cnt_q              <= cnt_q + 6'h01;
            tx_reference_clock <= cnt_q[2];
            if (cnt_q[2:0] == 3'h0)
            begin
                txWordValid   <= cnt_q[5:3] inside {[1:4]};
                tx_fault_code <= cnt_q[5:3] inside {4, 5};
                // pulled-down bus reads zero outside a frame
                txWord <= cnt_q[5:3] inside {[1:4]} ? {cnt_q, 10'h25A} : 16'h0000;
            end
        end
    end
endmodule

// ==== sdf_framing_port_tb.sv ====
`timescale 1ns/1ps
module sdf_framing_port_tb;
    // driven pins
    logic              sys_clk = 1'h0;
    logic              arst_n, deviceEnable, pattern_test_enable, rxBitTick, signal_loss;
    logic              psel, penable, pwrite;
    logic [11:0]       paddr;
    logic [31:0]       pwdata;
    sdf_pkg::sdf_sym_t rxSym;
    // observed pins
    logic              tx_reference_clock, txWordValid, tx_fault_code, txSymValid;
    logic [15:0]       txWord, rxDataOut;
    sdf_pkg::sdf_sym_t txSym;
    logic              rxWordClock, rxDataOe, rxFaultOut, rxFaultOe, rxValidOut, rxValidOe;
    logic              pready, pslverr, er;
    logic [31:0]       prdata, rd;
    // bookkeeping
    int                fails, samplesChecked, cyc, k;
    // receive table: code pair, {loss, pattern}, {data check, valid, fault, data}
    sdf_pkg::sdf_sym_t rs [8];
    logic [1:0]        rl [8];
    logic [18:0]       re [8];

    sdf_framing_port #(.PorCycles(4)) dut_u (
        .sys_clk(sys_clk), .arst_n(arst_n), .deviceEnable(deviceEnable),
        .pattern_test_enable(pattern_test_enable), .factory_test_enable(1'h0),
        .tx_reference_clock(tx_reference_clock), .txWord(txWord), .txWordValid(txWordValid),
        .tx_fault_code(tx_fault_code), .txSymValid(txSymValid), .txSym(txSym),
        .rxBitTick(rxBitTick), .rxSym(rxSym), .signal_loss(signal_loss),
        .rxWordClock(rxWordClock), .rxDataOut(rxDataOut), .rxDataOe(rxDataOe),
        .rxFaultOut(rxFaultOut), .rxFaultOe(rxFaultOe), .rxValidOut(rxValidOut),
        .rxValidOe(rxValidOe), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));

    sdf_proto_model pm_u (
        .sys_clk(sys_clk), .arst_n(arst_n), .tx_reference_clock(tx_reference_clock),
        .txWord(txWord), .txWordValid(txWordValid), .tx_fault_code(tx_fault_code));

    // clock, bit ticks every other cycle, hang guard
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) rxBitTick <= ~rxBitTick;
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            fails++;
            summarize();
        end
    end

    // compare and count
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samplesChecked++;
        if (g !== e)
        begin
            fails++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask

    // one bus transfer, result left in rd and er
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'h1;
        do @(posedge sys_clk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask

    // return at the edge where the word clock is first seen low again
    task automatic waitFall();
        int n;
        n = 0;
        do @(posedge sys_clk); while (rxWordClock !== 1'h1 && n++ < 200);
        do @(posedge sys_clk); while (rxWordClock !== 1'h0 && n++ < 200);
        if (n > 200) fails++;
    endtask

    task automatic summarize();
        $display("checked %0d failed %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // main sequence
    initial
    begin
        rs = '{{1'h0, 8'h12, 1'h0, 8'h34}, {1'h0, 8'hAB, 1'h0, 8'hCD},
               {1'h1, sdf_pkg::CODE_K30_7, 1'h1, sdf_pkg::CODE_K30_7},
               {1'h1, sdf_pkg::CODE_K23_7, 1'h1, sdf_pkg::CODE_K23_7},
               {1'h0, sdf_pkg::CODE_D5_6, 1'h1, sdf_pkg::CODE_K28_5},
               {1'h0, 8'h12, 1'h0, 8'h34}, {1'h0, 8'h95, 1'h0, 8'hCD},
               {1'h1, sdf_pkg::CODE_K30_7, 1'h1, sdf_pkg::CODE_K30_7}};
        rl = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h1, 2'h1};
        re = '{19'h6_1234, 19'h6_ABCD, 19'h3_0000, 19'h1_0000, 19'h0_0000, 19'h7_FFFF, 19'h7_95CD,
              19'h2_0000};
        {arst_n, pattern_test_enable, rxBitTick, signal_loss, psel, penable, pwrite} = 7'h00;
        deviceEnable = 1'h1;
        rxSym        = '0;
        paddr        = 12'h000;
        pwdata       = 32'h0000_0000;
        repeat (5) @(posedge sys_clk);
        arst_n <= 1'h1;
        // registers: reset value, refused address, mode and soft power-down
        apb(1'h0, sdf_pkg::REG_CTRL, 32'h0000_0000);
        chk("ctrl reset", {30'h0, sdf_pkg::CTRL_RESET}, rd);
        apb(1'h1, 12'h00C, 32'h0000_0003);
        chk("unmapped error", 32'h1, {31'h0, er});
        apb(1'h0, 12'h00C, 32'h0000_0000);
        chk("unmapped data", 32'h0, rd);
        waitFall();
        apb(1'h0, sdf_pkg::REG_STATUS, 32'h0000_0000);
        chk("status run", 32'h4, {29'h0, rd[2:0]});
        apb(1'h1, sdf_pkg::REG_CTRL, 32'h0000_0001);
        apb(1'h0, sdf_pkg::REG_CTRL, 32'h0000_0000);
        chk("ctrl readback", 32'h1, rd);
        apb(1'h0, sdf_pkg::REG_STATUS, 32'h0000_0000);
        chk("status down", 32'h1, {29'h0, rd[2:0]});
        apb(1'h1, sdf_pkg::REG_CTRL, 32'h0000_0000);
        waitFall();
        waitFall();
        chk("data drive", 32'h1, rxDataOe);
        // received words, one per word clock period
        for (k = 0; k < 8; k++)
        begin
            signal_loss         <= rl[k][1];
            pattern_test_enable <= rl[k][0];
            rxSym               <= rs[k];
            waitFall();
            chk("rxValidOut", re[k][17], rxValidOut);
            chk("rxFaultOut", re[k][16], rxFaultOut);
            if (re[k][18]) chk("rxDataOut", re[k][15:0], rxDataOut);
        end
        // power-down shows the detector, re-enable floats the pins
        pattern_test_enable <= 1'h0;
        deviceEnable        <= 1'h0;
        signal_loss         <= 1'h1;
        repeat (6) @(posedge sys_clk);
        chk("pd valid drive", 32'h1, rxValidOe);
        chk("pd loss", 32'h0, rxValidOut);
        chk("pd fault drive", 32'h0, rxFaultOe);
        signal_loss <= 1'h0;
        repeat (6) @(posedge sys_clk);
        chk("pd signal", 32'h1, rxValidOut);
        deviceEnable <= 1'h1;
        repeat (4) @(posedge sys_clk);
        chk("por fault drive", 32'h0, rxFaultOe);
        chk("por valid drive", 32'h0, rxValidOe);
        chk("por word clock", 32'h0, rxWordClock);
        waitFall();
        apb(1'h0, sdf_pkg::REG_STATUS, 32'h0000_0000);
        chk("status rerun", 32'h4, {29'h0, rd[2:0]});
        summarize();
    end
endmodule
